// *** src/clock_gen_status_flags.v ***
`timescale 1ns/1ps
`include "status_flags_defs.vh"

module clock_gen_status_flags (
  input  wire        core_clk,          // 20 MHz clock
  input  wire        reset,             // Async reset, active high
  input  wire        reset_sync_pin_n,  // Hard reset from reset/sync pin, active low
  input  wire [7:0]  reg_addr,          // Serial interface register address
  input  wire        reg_rd,            // Read strobe, one cycle
  input  wire        reg_wr,            // Write strobe, one cycle
  input  wire [15:0] reg_wdata,         // Write data
  output reg  [15:0] reg_rdata,         // Read data, valid cycle after reg_rd
  output reg         reg_rvalid,        // Read data valid pulse
  input  wire        pll_locked,        // Live PLL lock from lock detector
  input  wire        freq_locked,       // Frequency lock indication
  input  wire        vco_ready,         // VCO buffer LDO power-on status
  input  wire        amp_cal_round_done,// Pulse per amplitude calibration round
  input  wire        main_cal_done,     // Pulse at end of main calibration
  input  wire        recal_start,       // Pulse starting a recalibration
  input  wire        ee_rd_phase,       // EEPROM engine in read phase
  input  wire        ee_wr_phase,       // EEPROM engine in write phase
  input  wire        ee_op_req,         // Pulse: any EEPROM operation requested
  input  wire        eeprom_commit_cmd, // Pulse: EEPROM commit submitted
  input  wire        register_commit_cmd,// Pulse: register commit submitted
  input  wire        csum_update_cmd,   // Pulse: checksum update issued
  input  wire        csum_done,         // Pulse: config readback checksum complete
  input  wire [15:0] live_csum,         // Checksum computed while reading EEPROM
  input  wire [15:0] stored_csum,       // Checksum stored in EEPROM
  input  wire        xfer_done,         // Pulse: EEPROM to register transfer done
  input  wire [15:0] misc_status,       // Miscellaneous status word
  output reg  [15:0] health_flags_out,  // Health flags word mirror
  output reg         ee_busy            // EEPROM busy, for host gating
);

  // ****************************************
  // State
  // ****************************************
  reg        rd_coll_r;
  reg        wr_coll_r;
  reg        rd_range_r;
  reg        wr_range_r;
  reg        csum_err_r;
  reg        cal_done_r;
  reg        cfg_done_r;
  reg        unlock_sticky_r;
  reg        csum_ok_r;
  reg  [1:0] amp_rounds_r;
  reg [15:0] live_csum_r;
  reg [15:0] stored_csum_r;
  wire       busy_now;
  wire       rd_hit;
  wire [15:0] health_word;

  function in_map;
    input [7:0] a;
    begin
      in_map = (a <= `ADDR_LAST_REG);
    end
  endfunction

  assign busy_now = ee_rd_phase | ee_wr_phase;
  assign rd_hit   = reg_rd && (reg_addr == `ADDR_HEALTH_FLAGS);

  assign health_word = {4'h0,
                        pll_locked,
                        vco_ready,
                        rd_coll_r, wr_coll_r, rd_range_r, wr_range_r,
                        csum_err_r, busy_now, cal_done_r, cfg_done_r,
                        unlock_sticky_r,
                        freq_locked};

  // ****************************************
  // Flags
  // ****************************************
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rd_coll_r       <= 1'b0;
      wr_coll_r       <= 1'b0;
      rd_range_r      <= 1'b0;
      wr_range_r      <= 1'b0;
      csum_err_r      <= 1'b0;
      csum_ok_r       <= 1'b0;
      cal_done_r      <= 1'b0;
      cfg_done_r      <= 1'b0;
      unlock_sticky_r <= 1'b0;
      amp_rounds_r    <= 2'h0;
      live_csum_r     <= `RST_WORD16;
      stored_csum_r   <= `RST_WORD16;
    end else begin
      // Set wins over read-clear so a collision in the read cycle is kept
      if (ee_op_req && ee_rd_phase)
        rd_coll_r <= 1'b1;
      else if (rd_hit)
        rd_coll_r <= 1'b0;
      if (ee_op_req && ee_wr_phase)
        wr_coll_r <= 1'b1;
      else if (rd_hit)
        wr_coll_r <= 1'b0;
      // Range errors have no clear path other than reset
      if (reg_rd && !in_map(reg_addr))
        rd_range_r <= 1'b1;
      if (reg_wr && !in_map(reg_addr))
        wr_range_r <= 1'b1;
      live_csum_r   <= live_csum;
      stored_csum_r <= stored_csum;
      if (csum_done) begin
        csum_ok_r  <= (stored_csum == live_csum);
        csum_err_r <= (stored_csum != live_csum);
      end else if (eeprom_commit_cmd || csum_update_cmd) begin
        csum_err_r <= 1'b0;
      end
      if (xfer_done && csum_ok_r)
        cfg_done_r <= 1'b1;
      // Recalibration restarts the done sequence
      if (recal_start) begin
        amp_rounds_r <= 2'h0;
        cal_done_r   <= 1'b0;
      end else begin
        if (amp_cal_round_done && amp_rounds_r != 2'h2)
          amp_rounds_r <= amp_rounds_r + 2'h1;
        if (main_cal_done && amp_rounds_r == 2'h2)
          cal_done_r <= 1'b1;
      end
      // Loss of lock beats a clear in the same cycle
      if (cal_done_r && !pll_locked)
        unlock_sticky_r <= 1'b1;
      else if (recal_start || !reset_sync_pin_n)
        unlock_sticky_r <= 1'b0;
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      reg_rdata        <= `RST_WORD16;
      reg_rvalid       <= 1'b0;
      health_flags_out <= `RST_WORD16;
      ee_busy          <= 1'b0;
    end else begin
      reg_rvalid       <= reg_rd;
      health_flags_out <= health_word;
      ee_busy          <= busy_now;
      if (reg_rd) begin
        case (reg_addr)
          `ADDR_HEALTH_FLAGS: reg_rdata <= health_word;
          `ADDR_MISC_STATUS:  reg_rdata <= misc_status;
          `ADDR_LIVE_CSUM:    reg_rdata <= live_csum_r;
          `ADDR_STORED_CSUM:  reg_rdata <= stored_csum_r;
          default:            reg_rdata <= `RST_WORD16;
        endcase
      end
    end
  end

endmodule // clock_gen_status_flags

// *** inc/status_flags_defs.vh ***
`ifndef STATUS_FLAGS_DEFS_VH
`define STATUS_FLAGS_DEFS_VH

// ****************************************
// Register offsets (word addresses)
// ****************************************
`define ADDR_HEALTH_FLAGS  8'h07
`define ADDR_MISC_STATUS   8'h08
`define ADDR_LIVE_CSUM     8'h09
`define ADDR_STORED_CSUM   8'h0A
`define ADDR_LAST_REG      8'h1F

// ****************************************
// Field positions in health_flags
// ****************************************
`define BIT_LOCK_LIVE      11
`define BIT_VCO_READY      10
`define BIT_RD_COLL        9
`define BIT_WR_COLL        8
`define BIT_RD_RANGE       7
`define BIT_WR_RANGE       6
`define BIT_CSUM_ERR       5
`define BIT_EE_BUSY        4
`define BIT_CAL_DONE       3
`define BIT_CFG_DONE       2
`define BIT_UNLOCK_STICKY  1
`define BIT_FREQ_LOCK      0

// ****************************************
// Reset values
// ****************************************
`define RST_WORD16         16'h0000

`endif

// *** verif/host_model.sv ***
`timescale 1ns/1ps
module host_model (
  input  wire core_clk,  // Clock
  input  wire ee_busy,   // Device EEPROM busy
  input  wire op_in,     // Bench asks for EEPROM access
  input  wire bad,       // Bench orders access while busy
  output wire ee_op_req  // Request to device
);
  // Held back while busy; collisions only when the bench orders them
  assign ee_op_req = op_in & (~ee_busy | bad);
endmodule // host_model

// *** verif/status_flags_asserts.sv ***
`timescale 1ns/1ps
module status_flags_asserts (
  input wire        core_clk,         // Clock
  input wire        reset,            // Async reset
  input wire        reset_sync_pin_n, // Hard reset pin
  input wire [7:0]  reg_addr,         // Address
  input wire        reg_rd,           // Read strobe
  input wire        reg_wr,           // Write strobe
  input wire        reg_rvalid,       // Read valid
  input wire        pll_locked,       // PLL lock
  input wire        freq_locked,      // Frequency lock
  input wire        recal_start,      // Recalibration
  input wire        ee_rd_phase,      // Read phase
  input wire        ee_wr_phase,      // Write phase
  input wire        ee_op_req,        // EEPROM request
  input wire [15:0] health_flags_out, // Flags
  input wire        ee_busy           // Busy
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  a_read_answer: assert property (reg_rd |=> reg_rvalid) else $error("no read answer");
  a_lock_live: assert property (!$past(reset) |-> health_flags_out[11] == $past(pll_locked))
    else $error("live lock wrong");
  // Flag register updates on the first edge, the mirrored word one edge later
  a_rd_collision: assert property (ee_rd_phase && ee_op_req |-> ##2 health_flags_out[9])
    else $error("read collision missed");
  a_wr_collision: assert property (ee_wr_phase && ee_op_req |-> ##2 health_flags_out[8])
    else $error("write collision missed");
  a_rd_range: assert property (reg_rd && reg_addr > 8'h1F |-> ##2 health_flags_out[7])
    else $error("read range missed");
  a_wr_range: assert property (reg_wr && reg_addr > 8'h1F |-> ##2 health_flags_out[6])
    else $error("write range missed");
  a_busy_phase: assert property (!$past(reset) |-> ee_busy == $past(ee_rd_phase | ee_wr_phase))
    else $error("busy wrong");
  a_sticky_hold: assert property (health_flags_out[1] && $past(reset_sync_pin_n) && !$past(recal_start) |=>
    health_flags_out[1]) else $error("sticky lost");
  a_freq_lock: assert property (!$past(reset) |-> health_flags_out[0] == $past(freq_locked))
    else $error("freq lock wrong");
endmodule // status_flags_asserts
bind clock_gen_status_flags status_flags_asserts u_chk (.core_clk, .reset, .reset_sync_pin_n, .reg_addr, .reg_rd,
  .reg_wr, .reg_rvalid, .pll_locked, .freq_locked, .recal_start, .ee_rd_phase, .ee_wr_phase, .ee_op_req,
  .health_flags_out, .ee_busy);

// *** verif/tb.sv ***
`timescale 1ns/1ps
module tb;
  reg core_clk, reset, reset_sync_pin_n, reg_rd, reg_wr, pll_locked, freq_locked, vco_ready, ee_rd_phase;
  reg ee_wr_phase, op_in, bad;
  reg [7:0] reg_addr, pz;
  reg [15:0] reg_wdata, live_csum, stored_csum, misc_status;
  wire [15:0] reg_rdata, health_flags_out;
  wire reg_rvalid, ee_busy, ee_op_req;
  integer bad_count = 0, checked = 0, cyc = 0, i;
  host_model host (.core_clk, .ee_busy, .op_in, .bad, .ee_op_req);
  clock_gen_status_flags dut (.core_clk, .reset, .reset_sync_pin_n, .reg_addr, .reg_rd, .reg_wr, .reg_wdata,
    .reg_rdata, .reg_rvalid, .pll_locked, .freq_locked, .vco_ready, .amp_cal_round_done(pz[0]),
    .main_cal_done(pz[1]), .recal_start(pz[2]), .ee_rd_phase, .ee_wr_phase, .ee_op_req,
    .eeprom_commit_cmd(pz[3]), .register_commit_cmd(pz[4]), .csum_update_cmd(pz[5]), .csum_done(pz[6]),
    .live_csum, .stored_csum, .xfer_done(pz[7]), .misc_status, .health_flags_out, .ee_busy);
  task finish_test; begin
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  end endtask
  task chk(input [15:0] e, input [15:0] s); begin
    checked = checked + 1;
    if (e !== s) begin
      bad_count = bad_count + 1;
      $display("Error reg_rdata at %h expected %h seen %h", reg_addr, e, s);
    end
  end endtask
  task acc(input [7:0] a, input w, input [15:0] e); begin
    @(negedge core_clk); reg_addr = a; reg_rd = ~w; reg_wr = w;
    @(negedge core_clk);
    // Answer stands only in the cycle after the strobe; out-of-range data is not judged
    if (!w && a <= 8'h1F) chk(e, reg_rvalid ? reg_rdata : 16'hDEAD);
    reg_rd = 1'b0; reg_wr = 1'b0;
  end endtask
  task pulse(input [7:0] m); begin
    @(negedge core_clk); pz = m;
    @(negedge core_clk); pz = 8'h00;
  end endtask
  task op; begin
    @(negedge core_clk); op_in = 1'b1; bad = 1'b1;
    @(negedge core_clk); op_in = 1'b0; bad = 1'b0;
  end endtask
  initial begin core_clk = 1'b0; forever #25 core_clk = ~core_clk; end
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin bad_count = bad_count + 1; finish_test; end
  end
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    {reset, reset_sync_pin_n} = 2'b11; {reg_rd, reg_wr, pll_locked, freq_locked, vco_ready} = 5'h00;
    {ee_rd_phase, ee_wr_phase, op_in, bad} = 4'h0; reg_addr = 8'h00; pz = 8'h00; reg_wdata = 16'hFFFF;
    live_csum = 16'h1234; stored_csum = 16'h1234; misc_status = 16'hA5C3;
    repeat (8) @(negedge core_clk); reset = 1'b0;
    acc(8'h07, 0, 16'h0000); acc(8'h08, 0, 16'hA5C3); acc(8'h1F, 0, 16'h0000);
    acc(8'h09, 0, 16'h1234); acc(8'h0A, 0, 16'h1234);
    acc(8'h07, 1, 16'h0000); acc(8'h07, 0, 16'h0000);
    {pll_locked, freq_locked, vco_ready} = 3'b111; acc(8'h07, 0, 16'h0C01);
    pulse(8'h01); pulse(8'h01); pulse(8'h02); acc(8'h07, 0, 16'h0C09);
    pll_locked = 1'b0; acc(8'h07, 0, 16'h040B);
    pll_locked = 1'b1; acc(8'h07, 0, 16'h0C0B);
    reset_sync_pin_n = 1'b0; @(negedge core_clk); reset_sync_pin_n = 1'b1; acc(8'h07, 0, 16'h0C09);
    pll_locked = 1'b0; @(negedge core_clk); pll_locked = 1'b1; pulse(8'h04); acc(8'h07, 0, 16'h0C01);
    ee_rd_phase = 1'b1; op; acc(8'h07, 0, 16'h0E11); acc(8'h07, 0, 16'h0C11);
    ee_rd_phase = 1'b0; ee_wr_phase = 1'b1; op; acc(8'h07, 0, 16'h0D11);
    ee_wr_phase = 1'b0; @(negedge core_clk); acc(8'h07, 0, 16'h0C01);
    acc(8'h20, 0, 16'h0000); acc(8'h20, 1, 16'h0000); acc(8'h07, 0, 16'h0CC1);
    stored_csum = 16'h4321;
    for (i = 0; i < 2; i = i + 1) begin
      pulse(8'h40); acc(8'h07, 0, 16'h0CE1);
      pulse(i ? 8'h20 : 8'h08); acc(8'h07, 0, 16'h0CC1);
    end
    stored_csum = 16'h1234; pulse(8'h40); pulse(8'h80); acc(8'h07, 0, 16'h0CC5);
    finish_test;
  end
endmodule // tb
